// File: rtl/cfg_hdr_pkg.sv
/*
  Constants and carrier types for the identification and command/status
  configuration words. Assumes a single clock and synchronous resets.
*/
// Summary of operation
// - Parity errors from master or target set flag
// - SERR assertion on address parity sets flag
// - Own transaction master-aborted sets flag
// - Own transaction target-aborted sets flag
// - Target terminating with target-abort sets flag
// - Device select timing reads constant 01
// - PERR seen as master sets flag if enabled
// - Target back-to-back capable reads constant 1
// - High speed capable reads constant 0
// - Capability list bit reads 1, pointer offset reads 0
// - Master back-to-back enable reads constant 0
// - System error enable read/write, gates SERR
// - Wait cycle control reads constant 0
// - Parity response read/write, gates PERR reporting
// - Parity generation never gated by parity response
// - Palette snoop reads constant 0
// - Identifiers loaded by global reset or local write only
// - Bus master enable read/write, preset option
// - Memory space enable gates memory claims
// - I/O space enable gates I/O claims
// - Every error flag can raise interrupt request
package cfg_hdr_pkg;
  localparam logic [7:0]  ID_OFFSET            = 8'h00;
  localparam logic [7:0]  CMD_STATUS_OFFSET    = 8'h04;
  localparam logic [7:0]  CAP_POINTER_OFFSET   = 8'h34;
  // Default identity values are arbitrary
  localparam logic [15:0] DEVICE_ID_RESET      = 16'h0001;
  localparam logic [15:0] VENDOR_ID_RESET      = 16'h0001;
  localparam int          BIT_DETECTED_PARITY  = 31;
  localparam int          BIT_SIGNALLED_SERR   = 30;
  localparam int          BIT_RECEIVED_MABORT  = 29;
  localparam int          BIT_RECEIVED_TABORT  = 28;
  localparam int          BIT_SIGNALLED_TABORT = 27;
  localparam int          BIT_DEVICE_SELECT_TIMING_LSB       = 25;
  localparam int          BIT_MASTER_PARITY    = 24;
  localparam int          BIT_TARGET_B2B       = 23;
  localparam int          BIT_HIGH_SPEED       = 21;
  localparam int          BIT_CAP_LIST         = 20;
  localparam int          BIT_MASTER_B2B       = 9;
  localparam int          BIT_SERR_ENABLE      = 8;
  localparam int          BIT_WAIT_CONTROL     = 7;
  localparam int          BIT_PARITY_RESPONSE  = 6;
  localparam int          BIT_PALETTE_SNOOP    = 5;
  localparam int          BIT_WRITE_INVALIDATE = 4;
  localparam int          BIT_SPECIAL_CYCLES   = 3;
  localparam int          BIT_BUS_MASTER       = 2;
  localparam int          BIT_MEMORY_SPACE     = 1;
  localparam int          BIT_IO_SPACE         = 0;
  localparam logic [1:0]  DEVICE_SELECT_TIMING_MEDIUM        = 2'h1;
  localparam logic [31:0] W1C_MASK             = 32'hf9000000;
  localparam logic [31:0] RW_MASK              = 32'h00000147;

  typedef struct packed {
    logic master_data_parity;
    logic target_parity;
    logic target_addr_parity;
    logic master_abort;
    logic target_abort_recv;
    logic target_abort_sent;
    logic perr_by_master;
    logic perr_by_target;
  } bus_events_t;
endpackage

// File: rtl/pci_config_id_and_cmd_status.sv
/*
  Identification word and command/status word of the configuration header.
  Assumes configuration cycles arrive decoded as one-cycle strobes, bus event
  pulses come from the master and target logic, all on clk_i.
*/
module pci_config_id_and_cmd_status
  import cfg_hdr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        pci_reset_i,
  input  wire logic        bus_master_preset_i,
  input  wire logic        cfg_write_i,
  input  wire logic        cfg_read_i,
  input  wire logic [7:0]  cfg_offset_i,
  input  wire logic [3:0]  cfg_byte_en_i,
  input  wire logic [31:0] cfg_wdata_i,
  input  wire logic        local_id_write_i,
  input  wire logic [31:0] local_id_data_i,
  input  wire bus_events_t events_i,
  input  wire logic        parity_in_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_ack_o,
  output logic             serr_drive_o,
  output logic             perr_drive_o,
  output logic             parity_out_o,
  output logic             master_allowed_o,
  output logic             memory_claim_en_o,
  output logic             io_claim_en_o,
  output logic             error_irq_o
);
  logic [31:0] identification_word;
  logic [5:0]  flags;
  logic        system_error_enable;
  logic        parity_error_response;
  logic        bus_master_enable;
  logic        memory_space_enable;
  logic        io_space_enable;
  logic [31:0] byte_mask;
  logic [31:0] status_word;
  logic [31:0] w1c_bits;
  logic        serr_event;
  logic        perr_event;
  logic [5:0]  set_bits;

  default clocking cb_cfg @(posedge clk_i);
  endclocking
  default disable iff (pci_reset_i);

  assign byte_mask = {{8{cfg_byte_en_i[3]}}, {8{cfg_byte_en_i[2]}},
                      {8{cfg_byte_en_i[1]}}, {8{cfg_byte_en_i[0]}}};
  assign w1c_bits = (cfg_write_i && cfg_offset_i == CMD_STATUS_OFFSET)
                  ? (cfg_wdata_i & byte_mask & W1C_MASK) : 32'h0;
  assign serr_event = events_i.target_addr_parity && system_error_enable
                    && parity_error_response;
  assign perr_event = parity_error_response
                    && (events_i.master_data_parity || events_i.target_parity);

  // Flags: detected parity, serr, master abort, target abort rx/tx, master data parity
  assign set_bits[5] = events_i.master_data_parity || events_i.target_parity
                     || events_i.target_addr_parity;
  assign set_bits[4] = serr_event;
  assign set_bits[3] = events_i.master_abort;
  assign set_bits[2] = events_i.target_abort_recv;
  assign set_bits[1] = events_i.target_abort_sent;
  assign set_bits[0] = parity_error_response
                     && (events_i.perr_by_master || events_i.perr_by_target);

  // Hardware set beats a simultaneous write-one clear
  always_ff @(posedge clk_i)
  begin
    if (pci_reset_i)
      flags <= 6'h00;
    else
      flags <= (flags & ~{w1c_bits[31:27], w1c_bits[24]}) | set_bits;
  end

  always_ff @(posedge clk_i)
  begin
    if (pci_reset_i)
    begin
      system_error_enable   <= 1'b0;
      parity_error_response <= 1'b0;
      memory_space_enable   <= 1'b0;
      io_space_enable       <= 1'b0;
    end
    else if (cfg_write_i && cfg_offset_i == CMD_STATUS_OFFSET)
    begin
      if (cfg_byte_en_i[1])
        system_error_enable <= cfg_wdata_i[BIT_SERR_ENABLE];
      if (cfg_byte_en_i[0])
      begin
        parity_error_response <= cfg_wdata_i[BIT_PARITY_RESPONSE];
        memory_space_enable   <= cfg_wdata_i[BIT_MEMORY_SPACE];
        io_space_enable       <= cfg_wdata_i[BIT_IO_SPACE];
      end
    end
  end

  // Preset option sampled while the bus reset is held
  always_ff @(posedge clk_i)
  begin
    if (pci_reset_i)
      bus_master_enable <= bus_master_preset_i;
    else if (cfg_write_i && cfg_offset_i == CMD_STATUS_OFFSET && cfg_byte_en_i[0])
      bus_master_enable <= cfg_wdata_i[BIT_BUS_MASTER];
  end

  // Configuration writes to the identity are ignored
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      identification_word <= {DEVICE_ID_RESET, VENDOR_ID_RESET};
    else if (local_id_write_i)
      identification_word <= local_id_data_i;
  end

  always_comb
  begin
    status_word = 32'h0;
    status_word[BIT_DETECTED_PARITY]  = flags[5];
    status_word[BIT_SIGNALLED_SERR]   = flags[4];
    status_word[BIT_RECEIVED_MABORT]  = flags[3];
    status_word[BIT_RECEIVED_TABORT]  = flags[2];
    status_word[BIT_SIGNALLED_TABORT] = flags[1];
    status_word[BIT_DEVICE_SELECT_TIMING_LSB+:2]    = DEVICE_SELECT_TIMING_MEDIUM;
    status_word[BIT_MASTER_PARITY]    = flags[0];
    status_word[BIT_TARGET_B2B]       = 1'b1;
    status_word[BIT_HIGH_SPEED]       = 1'b0;
    status_word[BIT_CAP_LIST]         = 1'b1;
    status_word[BIT_MASTER_B2B]       = 1'b0;
    status_word[BIT_SERR_ENABLE]      = system_error_enable;
    status_word[BIT_WAIT_CONTROL]     = 1'b0;
    status_word[BIT_PARITY_RESPONSE]  = parity_error_response;
    status_word[BIT_PALETTE_SNOOP]    = 1'b0;
    status_word[BIT_WRITE_INVALIDATE] = 1'b0;
    status_word[BIT_SPECIAL_CYCLES]   = 1'b0;
    status_word[BIT_BUS_MASTER]       = bus_master_enable;
    status_word[BIT_MEMORY_SPACE]     = memory_space_enable;
    status_word[BIT_IO_SPACE]         = io_space_enable;
  end

  always_ff @(posedge clk_i)
  begin
    if (pci_reset_i)
    begin
      cfg_rdata_o <= 32'h0;
      cfg_ack_o   <= 1'b0;
    end
    else
    begin
      cfg_ack_o <= cfg_read_i || cfg_write_i;
      if (cfg_read_i && cfg_offset_i == ID_OFFSET)
        cfg_rdata_o <= identification_word;
      else if (cfg_read_i && cfg_offset_i == CMD_STATUS_OFFSET)
        cfg_rdata_o <= status_word;
      else
        cfg_rdata_o <= 32'h0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (pci_reset_i)
    begin
      serr_drive_o      <= 1'b0;
      perr_drive_o      <= 1'b0;
      master_allowed_o  <= 1'b0;
      memory_claim_en_o <= 1'b0;
      io_claim_en_o     <= 1'b0;
      error_irq_o       <= 1'b0;
    end
    else
    begin
      serr_drive_o      <= serr_event;
      perr_drive_o      <= perr_event;
      master_allowed_o  <= bus_master_enable;
      memory_claim_en_o <= memory_space_enable;
      io_claim_en_o     <= io_space_enable;
      error_irq_o       <= |flags;
    end
  end

  // Parity is generated with no reference to the response enable
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      parity_out_o <= 1'b0;
    else
      parity_out_o <= parity_in_i;
  end

  // Read of the command/status word, answered on the next edge
  sequence s_status_read;
    cfg_read_i && cfg_offset_i == CMD_STATUS_OFFSET;
  endsequence

  sequence s_status_answer;
    cfg_ack_o && cfg_rdata_o[BIT_DEVICE_SELECT_TIMING_LSB+:2] == DEVICE_SELECT_TIMING_MEDIUM
      && cfg_rdata_o[BIT_TARGET_B2B] && !cfg_rdata_o[BIT_HIGH_SPEED]
      && cfg_rdata_o[BIT_CAP_LIST];
  endsequence

  sequence s_id_read;
    cfg_read_i && cfg_offset_i == ID_OFFSET;
  endsequence

  sequence s_other_read;
    cfg_read_i && cfg_offset_i != ID_OFFSET && cfg_offset_i != CMD_STATUS_OFFSET;
  endsequence

  // Data parity error seen while reporting is enabled
  sequence s_perr_reported;
    parity_error_response && (events_i.master_data_parity || events_i.target_parity);
  endsequence

  // System error reporting
  a_serr_needs_enable: assert property (
    serr_drive_o |-> $past(system_error_enable) && $past(parity_error_response))
    else $error("serr driven while disabled");
  a_serr_sets_flag: assert property (
    serr_drive_o |-> flags[4])
    else $error("serr flag not set");
  a_serr_on_fault: assert property (
    events_i.target_addr_parity && system_error_enable && parity_error_response
    |=> serr_drive_o)
    else $error("serr not driven on address parity");
  a_serr_flag_gated: assert property (
    $rose(flags[4]) |-> $past(system_error_enable) && $past(parity_error_response))
    else $error("serr flag set while disabled");

  // Error flags follow their events; a set beats a clear
  a_parity_flag_set: assert property (
    events_i.target_parity |=> flags[5])
    else $error("detected parity flag missed");
  a_addr_parity_flag: assert property (
    events_i.target_addr_parity |=> flags[5])
    else $error("address parity flag missed");
  a_master_parity_flag: assert property (
    events_i.master_data_parity |=> flags[5])
    else $error("master data parity flag missed");
  a_mabort_flag_set: assert property (
    events_i.master_abort |=> flags[3] [*1] ##1 (flags[3] || $past(w1c_bits[BIT_RECEIVED_MABORT])))
    else $error("master abort flag missed");
  a_tabort_rx_set: assert property (
    events_i.target_abort_recv |=> status_word[BIT_RECEIVED_TABORT])
    else $error("received target abort missed");
  a_tabort_tx_set: assert property (
    events_i.target_abort_sent |=> status_word[BIT_SIGNALLED_TABORT])
    else $error("signalled target abort missed");
  a_mdp_gated: assert property (
    $rose(flags[0]) |-> $past(parity_error_response))
    else $error("master parity flag set while disabled");
  a_mdp_flag_set: assert property (
    parity_error_response && (events_i.perr_by_master || events_i.perr_by_target)
    |=> flags[0])
    else $error("master parity flag missed");
  a_flag_clear: assert property (
    w1c_bits[BIT_SIGNALLED_TABORT] && !events_i.target_abort_sent |=> !flags[1])
    else $error("write one did not clear");
  a_set_beats_clear: assert property (
    w1c_bits[BIT_SIGNALLED_TABORT] && events_i.target_abort_sent |=> flags[1])
    else $error("clear won over a new event");

  // Parity error signalling
  a_perr_gated: assert property (
    perr_drive_o |-> $past(parity_error_response))
    else $error("perr driven while disabled");
  a_perr_on_error: assert property (
    s_perr_reported |=> perr_drive_o)
    else $error("perr not driven");

  // Read answers and acknowledge
  a_fixed_bits: assert property (
    s_status_read |=> s_status_answer)
    else $error("constant status bits wrong");
  a_fixed_zero_bits: assert property (
    s_status_read |=> !cfg_rdata_o[BIT_MASTER_B2B] && !cfg_rdata_o[BIT_WAIT_CONTROL]
                      && !cfg_rdata_o[BIT_PALETTE_SNOOP])
    else $error("constant zero bits wrong");
  a_id_read: assert property (
    s_id_read |=> cfg_rdata_o == $past(identification_word))
    else $error("identification read wrong");
  a_other_reads_zero: assert property (
    s_other_read |=> cfg_rdata_o == 32'h0)
    else $error("unused offset read not zero");
  a_ack_follows: assert property (
    cfg_read_i || cfg_write_i |=> cfg_ack_o)
    else $error("request not acknowledged");
  a_ack_idle: assert property (
    !cfg_read_i && !cfg_write_i |=> !cfg_ack_o)
    else $error("acknowledge without request");

  // Identity is kept by the bus reset and by configuration writes
  a_id_cfg_ignored: assert property (
    disable iff (reset_i) cfg_write_i && !local_id_write_i |=> $stable(identification_word))
    else $error("identification changed by configuration write");
  a_id_global_only: assert property (
    disable iff (reset_i) pci_reset_i && !local_id_write_i |=> $stable(identification_word))
    else $error("identification changed by bus reset");

  // Enables, parity and interrupt outputs
  a_master_gated: assert property (
    master_allowed_o |-> $past(bus_master_enable))
    else $error("master allowed while disabled");
  a_memory_gated: assert property (
    memory_claim_en_o |-> $past(memory_space_enable))
    else $error("memory claim while disabled");
  a_io_gated: assert property (
    io_claim_en_o |-> $past(io_space_enable))
    else $error("io claim while disabled");
  a_parity_passes: assert property (
    disable iff (reset_i) !reset_i |=> parity_out_o == $past(parity_in_i))
    else $error("parity not passed through");
  a_irq_follows: assert property (
    (|flags) ##1 (|flags) |-> error_irq_o)
    else $error("interrupt not raised");
  a_irq_clears: assert property (
    !(|flags) |=> !error_irq_o)
    else $error("interrupt without flag");
endmodule

// File: bench/bus_agent_model.sv
/*
  Model of the bus master and target logic beside the configuration words.
  Assumes the bench calls pulse from its main sequence; all changes fall on
  the falling edge of clk_i.
*/
module bus_agent_model
  import cfg_hdr_pkg::*;
(
  input  wire logic  clk_i,
  output bus_events_t events_o,
  output logic        parity_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    events_o = '0;
    parity_o = 1'b0;
  end
  // Parity alternates every cycle so a stuck copy cannot pass
  always @(negedge clk_i)
    parity_o <= ~parity_o;
  // One-cycle event pulse; returns in the cycle after it was taken
  task automatic pulse(input bus_events_t ev);
    @(negedge clk_i);
    events_o = ev;
    @(negedge clk_i);
    events_o = '0;
  endtask
endmodule

// File: bench/tb_top.sv
/*
  Self-checking bench for the identification and command/status words.
  Assumes decoded one-cycle configuration strobes and the bus agent model.
*/
`define CHK(what, exp, got) \
  begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %s expected %h seen %h", what, exp, got); end end
module tb_top
  import cfg_hdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, reset_i, pci_reset_i, bus_master_preset_i;
  logic        cfg_write_i, cfg_read_i, local_id_write_i;
  logic [7:0]  cfg_offset_i;
  logic [3:0]  cfg_byte_en_i;
  logic [31:0] cfg_wdata_i, local_id_data_i, cfg_rdata_o;
  logic        cfg_ack_o, serr_drive_o, perr_drive_o, parity_out_o, parity_in_i;
  logic        master_allowed_o, memory_claim_en_o, io_claim_en_o, error_irq_o;
  bus_events_t events_i;
  int          n_errors, checks, cycles;
  logic [31:0] flag_of [8] = '{32'h80000000, 32'h80000000, 32'hc0000000, 32'h20000000,
                               32'h10000000, 32'h08000000, 32'h01000000, 32'h01000000};

  pci_config_id_and_cmd_status uut (.clk_i(clk_i), .reset_i(reset_i),
    .pci_reset_i(pci_reset_i), .bus_master_preset_i(bus_master_preset_i),
    .cfg_write_i(cfg_write_i), .cfg_read_i(cfg_read_i), .cfg_offset_i(cfg_offset_i),
    .cfg_byte_en_i(cfg_byte_en_i), .cfg_wdata_i(cfg_wdata_i),
    .local_id_write_i(local_id_write_i), .local_id_data_i(local_id_data_i),
    .events_i(events_i), .parity_in_i(parity_in_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o), .serr_drive_o(serr_drive_o), .perr_drive_o(perr_drive_o),
    .parity_out_o(parity_out_o), .master_allowed_o(master_allowed_o),
    .memory_claim_en_o(memory_claim_en_o), .io_claim_en_o(io_claim_en_o),
    .error_irq_o(error_irq_o));
  bus_agent_model agent (.clk_i(clk_i), .events_o(events_i), .parity_o(parity_in_i));

  always #50 clk_i = ~clk_i;

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  // Request held over one rising edge; answer checked in the following cycle
  task automatic cfg_read(input logic [7:0] off, input logic [31:0] exp);
    @(negedge clk_i);
    cfg_read_i = 1'b1;
    cfg_offset_i = off;
    @(negedge clk_i);
    `CHK("read ack", 1'b1, cfg_ack_o)
    `CHK("read data", exp, cfg_rdata_o)
    cfg_read_i = 1'b0;
  endtask

  task automatic cfg_write(input logic [7:0] off, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk_i);
    cfg_write_i = 1'b1;
    cfg_offset_i = off;
    cfg_wdata_i = d;
    cfg_byte_en_i = be;
    @(negedge clk_i);
    `CHK("write ack", 1'b1, cfg_ack_o)
    cfg_write_i = 1'b0;
  endtask

  task automatic enables(input logic exp);
    `CHK("master allowed", exp, master_allowed_o)
    `CHK("memory claim", exp, memory_claim_en_o)
    `CHK("io claim", exp, io_claim_en_o)
  endtask

  initial
  begin
    {clk_i, cfg_write_i, cfg_read_i, local_id_write_i} = '0;
    {reset_i, pci_reset_i, bus_master_preset_i} = 3'h7;
    {cfg_offset_i, cfg_byte_en_i, cfg_wdata_i, local_id_data_i} = '0;
    n_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(negedge clk_i);
    {reset_i, pci_reset_i} = 2'h0;
    cfg_read(ID_OFFSET, {DEVICE_ID_RESET, VENDOR_ID_RESET});
    cfg_read(CMD_STATUS_OFFSET, 32'h02900004);
    `CHK("master allowed", 1'b1, master_allowed_o)
    cfg_write(ID_OFFSET, 32'hffffffff, 4'hf);
    cfg_read(ID_OFFSET, {DEVICE_ID_RESET, VENDOR_ID_RESET});
    @(negedge clk_i);
    local_id_write_i = 1'b1;
    local_id_data_i = 32'h5a5ac3c3;
    @(negedge clk_i);
    local_id_write_i = 1'b0;
    cfg_read(ID_OFFSET, 32'h5a5ac3c3);
    cfg_read(8'h08, 32'h00000000);
    cfg_write(CMD_STATUS_OFFSET, 32'h00000000, 4'hf);
    cfg_read(CMD_STATUS_OFFSET, 32'h02900000);
    enables(1'b0);
    cfg_write(CMD_STATUS_OFFSET, 32'hffffffff, 4'hf);
    cfg_read(CMD_STATUS_OFFSET, 32'h02900147);
    enables(1'b1);
    for (int i = 0; i < 8; i++)
    begin
      agent.pulse(8'h80 >> i);
      `CHK("serr drive", (i == 2), serr_drive_o)
      `CHK("perr drive", (i < 2), perr_drive_o)
      @(negedge clk_i);
      `CHK("error irq", 1'b1, error_irq_o)
      cfg_read(CMD_STATUS_OFFSET, 32'h02900147 | flag_of[i]);
      cfg_write(CMD_STATUS_OFFSET, 32'h00000147 | flag_of[i], 4'hf);
      cfg_read(CMD_STATUS_OFFSET, 32'h02900147);
      `CHK("error irq clear", 1'b0, error_irq_o)
    end
    cfg_write(CMD_STATUS_OFFSET, 32'h00000000, 4'h2);
    cfg_read(CMD_STATUS_OFFSET, 32'h02900047);
    cfg_write(CMD_STATUS_OFFSET, 32'h00000100, 4'hf);
    agent.pulse(8'h20);
    `CHK("serr gated", 1'b0, serr_drive_o)
    cfg_read(CMD_STATUS_OFFSET, 32'h82900100);
    cfg_write(CMD_STATUS_OFFSET, 32'h80000100, 4'h8);
    agent.pulse(8'h02);
    cfg_read(CMD_STATUS_OFFSET, 32'h02900100);
    // Event and write-one clear on the same edge: the event must win
    fork
      agent.pulse(8'h04);
      cfg_write(CMD_STATUS_OFFSET, 32'h08000100, 4'h8);
    join
    cfg_read(CMD_STATUS_OFFSET, 32'h0a900100);
    // Bus reset in mid-run with the master preset low
    @(negedge clk_i);
    {pci_reset_i, bus_master_preset_i} = 2'h2;
    repeat (2) @(negedge clk_i);
    pci_reset_i = 1'b0;
    cfg_read(CMD_STATUS_OFFSET, 32'h02900000);
    enables(1'b0);
    `CHK("error irq reset", 1'b0, error_irq_o)
    cfg_read(ID_OFFSET, 32'h5a5ac3c3);
    repeat (2)
    begin
      @(posedge clk_i);
      #1;
      `CHK("parity out", parity_in_i, parity_out_o)
    end
    give_verdict();
  end
endmodule
